// *** design/fbp_defines.svh ***
// Offsets, field positions, reset values and fixed constants of the flash boot/protect block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// Register byte offsets on the APB slave
`define FBP_OFS_CTRL 8'h00
`define FBP_OFS_STATUS 8'h04
`define FBP_OFS_PROTECT 8'h08
`define FBP_OFS_VECTOR 8'h0c
`define FBP_OFS_ID 8'h10
`define FBP_OFS_ERASE 8'h14
`define FBP_OFS_LOCK 8'h18

// Control register bit positions
`define FBP_CTRL_RW_EN 0
`define FBP_CTRL_AREA_SEL 1
`define FBP_CTRL_BLOCK_A 2
`define FBP_CTRL_EXPAND 3

// Identifier load register fields
`define FBP_ID_DATA_MSB 7
`define FBP_ID_IDX_MSB 10
`define FBP_ID_IDX_LSB 8

// Erase register bit: erase the block holding the protect code byte
`define FBP_ERASE_PROT 0

// Protect code byte layout and values
`define FBP_PROT_LVL_MSB 7
`define FBP_PROT_LVL_LSB 6
`define FBP_PROT_LVL_OFF 2'b11
`define FBP_BYTE_ZERO 8'h00
`define FBP_BYTE_ERASED 8'hff
`define FBP_PROT_RST 8'hff
`define FBP_PROT_BLOCK 3'h0

// Reset vector and identifier storage
`define FBP_VEC_RST 32'hffffffff
`define FBP_ID_BYTES 7
`define FBP_ID_LAST 3'h6
`define FBP_ID_ADDR0 24'h0fffdf

// Chip-select 2 span while block A is mapped
`define FBP_CS2_LO 20'h10000
`define FBP_CS2_HI 20'h26fff

// User area block count, one lock bit each
`define FBP_NUM_BLOCKS 8
`define FBP_LOCK_RST 8'h00

`endif

// *** design/fbp_id_mem.sv ***
// Small store for the programmer identifier bytes, registered read port.
// Assumes one clock and a synchronous active-high reset from the top.
`timescale 1ns/10ps
`include "fbp_defines.svh"

module fbp_id_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FBP_ID_BYTES,
  parameter int AW = 3
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Erased content after reset, so an unloaded store never matches a real code
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= {WIDTH{1'b1}};
      end
      rd_data_o <= {WIDTH{1'b1}};
    end else begin
      if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
        mem_reg[wr_addr_i] <= wr_data_i;
      end
      // Out-of-range index reads as erased
      rd_data_o <= (int'(rd_addr_i) < DEPTH) ? mem_reg[rd_addr_i] : {WIDTH{1'b1}};
    end
  end

endmodule : fbp_id_mem

// *** design/fbp_pkg.sv ***
// Types shared by the flash boot/protect block.
// Assumes fbp_defines.svh is on the include path.
`include "fbp_defines.svh"

package fbp_pkg;

  // Programmer link currently active, as decoded by the mode logic outside
  typedef enum logic [1:0] {
    FBP_PM_NONE = 2'b00,
    FBP_PM_SERIAL = 2'b01,
    FBP_PM_PARALLEL = 2'b11,
    FBP_PM_CAN = 2'b10
  } fbp_prog_mode_e;

  // Boot selection caught at reset release
  typedef enum logic [1:0] {
    FBP_BOOT_USER = 2'b00,
    FBP_BOOT_ROM = 2'b01,
    FBP_BOOT_OTHER = 2'b11
  } fbp_boot_e;

  typedef enum logic [1:0] {
    FBP_CMD_READ = 2'b00,
    FBP_CMD_PROGRAM = 2'b01,
    FBP_CMD_ERASE = 2'b11
  } fbp_cmd_kind_e;

  // Programmer command as presented to the gate
  typedef struct packed {
    fbp_cmd_kind_e kind;
    logic boot_area;
    logic byte_unit;
    logic [2:0] block;
  } fbp_cmd_s;

  typedef enum logic [1:0] {
    FBP_ID_FETCH = 2'b00,
    FBP_ID_READY = 2'b01,
    FBP_ID_DONE = 2'b11
  } fbp_id_state_e;

  typedef enum logic [2:0] {
    FBP_SEL_CTRL,
    FBP_SEL_STATUS,
    FBP_SEL_PROTECT,
    FBP_SEL_VECTOR,
    FBP_SEL_ID,
    FBP_SEL_ERASE,
    FBP_SEL_LOCK,
    FBP_SEL_NONE
  } fbp_sel_e;

  // State of the top module, all but the identifier store contents
  typedef struct packed {
    logic [1:0] sync_mode;
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic captured;
    fbp_boot_e boot;
    logic rw_en;
    logic area_sel;
    logic block_a;
    logic expand_wr;
    logic [7:0] protect;
    logic [31:0] vector;
    logic [`FBP_NUM_BLOCKS-1:0] lock;
    fbp_id_state_e id_st;
    logic [2:0] id_idx;
    logic id_miss;
    logic id_ok;
    logic [31:0] rdata;
    logic accept;
    logic reject;
    logic cs2_hit;
  } fbp_state_s;

endpackage : fbp_pkg

// *** design/fbp_top.sv ***
// Flash boot selection and rewrite protection: strap capture, area steering,
// CPU rewrite side effects, protect code gating and programmer identifier check.
// Assumes an APB master on mclk_i, straps from pins, programmer requests on mclk_i.
//
// Summary of operation
// - Reset release with mode strap high, A high, B low selects boot area.
// - Reset release with mode strap low runs from the user area.
// - Outside boot mode the shared range never returns boot area contents.
// - In boot mode the area select bit steers the shared range.
// - Boot area may be erased or programmed only in parallel mode.
// - Block A enable maps block A and the chip-select 2 span.
// - Rewrite enable forces expand bit high; clearing shows the last written expand bit.
// - Expand bit writes during rewrite take effect only after rewrite ends.
// - Entering rewrite sets the block A enable bit; the expand bit is only forced while rewrite is on.
// - Protect level other than 11b blocks parallel reads and rewrites.
// - Protect byte of 00h or FFh disables protection.
// - Erasing the protect byte block leaves that byte at FFh.
// - Serial and CAN commands are rejected on identifier mismatch.
// - Fully erased reset vector skips the identifier check.
// - Identifier is seven bytes, first byte at the lowest address.
// - Byte-unit programming only through the parallel interface.
// - A set lock bit blocks programming and erasure of that block.
`timescale 1ns/10ps
`include "fbp_defines.svh"

module fbp_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Strap pins, asynchronous
  input wire logic mode_strap_pin_i,
  input wire logic boot_strap_pin_a_i,
  input wire logic boot_strap_pin_b_i,
  // CPU address for region decode
  input wire logic [19:0] cpu_addr_i,
  // Programmer side
  input wire fbp_pkg::fbp_prog_mode_e prog_mode_i,
  input wire logic prog_id_start_i,
  input wire logic prog_id_valid_i,
  input wire logic [7:0] prog_id_byte_i,
  output logic prog_id_ready_o,
  input wire logic prog_cmd_valid_i,
  input wire fbp_pkg::fbp_cmd_s prog_cmd_i,
  output logic prog_cmd_accept_o,
  output logic prog_cmd_reject_o,
  // Status toward the memory system
  output fbp_pkg::fbp_boot_e boot_sel_o,
  output logic shared_to_boot_o,
  output logic block_a_en_o,
  output logic expand_eff_o,
  output logic cs2_hit_o,
  output logic par_access_ok_o,
  output logic id_ok_o
);

  // ---------------------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------------------

  // Register decode, shared by the read and write paths
  function automatic fbp_pkg::fbp_sel_e reg_sel(input logic [7:0] addr);
    case (addr)
      `FBP_OFS_CTRL: reg_sel = fbp_pkg::FBP_SEL_CTRL;
      `FBP_OFS_STATUS: reg_sel = fbp_pkg::FBP_SEL_STATUS;
      `FBP_OFS_PROTECT: reg_sel = fbp_pkg::FBP_SEL_PROTECT;
      `FBP_OFS_VECTOR: reg_sel = fbp_pkg::FBP_SEL_VECTOR;
      `FBP_OFS_ID: reg_sel = fbp_pkg::FBP_SEL_ID;
      `FBP_OFS_ERASE: reg_sel = fbp_pkg::FBP_SEL_ERASE;
      `FBP_OFS_LOCK: reg_sel = fbp_pkg::FBP_SEL_LOCK;
      default: reg_sel = fbp_pkg::FBP_SEL_NONE;
    endcase
  endfunction : reg_sel

  // Protection is live only for a real level code and a programmed byte
  function automatic logic prot_active(input logic [7:0] code);
    logic byte_off;
    byte_off = (code == `FBP_BYTE_ZERO) || (code == `FBP_BYTE_ERASED);
    prot_active = !byte_off &&
      (code[`FBP_PROT_LVL_MSB:`FBP_PROT_LVL_LSB] != `FBP_PROT_LVL_OFF);
  endfunction : prot_active

  // ---------------------------------------------------------------------------
  // State and wires
  // ---------------------------------------------------------------------------

  fbp_pkg::fbp_state_s st_reg;
  fbp_pkg::fbp_state_s st_next;

  fbp_pkg::fbp_sel_e sel;
  logic wr_access;
  logic rd_setup;
  logic [3:0] vec_byte_erased;
  logic vec_erased;
  logic prot_on;
  logic expand_eff;
  logic id_wr;
  logic [7:0] id_rd_data;

  assign sel = reg_sel(paddr_i);
  assign wr_access = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;
  assign prot_on = prot_active(st_reg.protect);
  assign expand_eff = st_reg.rw_en || st_reg.expand_wr;
  assign id_wr = wr_access && (sel == fbp_pkg::FBP_SEL_ID);

  // Each vector byte checked alone; all four must read erased
  for (genvar g = 0; g < 4; g++) begin : g_vec
    assign vec_byte_erased[g] = (st_reg.vector[g*8 +: 8] == `FBP_BYTE_ERASED);
  end
  assign vec_erased = &vec_byte_erased;

  // ---------------------------------------------------------------------------
  // Identifier store
  // ---------------------------------------------------------------------------

  // Index 0 holds the byte from the lowest identifier address
  fbp_id_mem #(
    .WIDTH(8),
    .DEPTH(`FBP_ID_BYTES),
    .AW(3)
  ) u_id_mem (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .wr_en_i(id_wr),
    .wr_addr_i(pwdata_i[`FBP_ID_IDX_MSB:`FBP_ID_IDX_LSB]),
    .wr_data_i(pwdata_i[`FBP_ID_DATA_MSB:0]),
    .rd_addr_i(st_reg.id_idx),
    .rd_data_o(id_rd_data)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------

  always_comb begin
    logic par;
    logic ser_can;
    logic cpu_src;
    logic ok;
    logic last_bad;
    par = 1'b0;
    ser_can = 1'b0;
    cpu_src = 1'b0;
    ok = 1'b0;
    last_bad = 1'b0;
    st_next = st_reg;

    // Synchronisers: the first stage feeds only the second
    st_next.sync_mode = {st_reg.sync_mode[0], mode_strap_pin_i};
    st_next.sync_a = {st_reg.sync_a[0], boot_strap_pin_a_i};
    st_next.sync_b = {st_reg.sync_b[0], boot_strap_pin_b_i};

    // Catch straps once, on the first cycle after reset release
    if (!st_reg.captured) begin
      st_next.captured = 1'b1;
      if (!st_reg.sync_mode[1]) begin
        st_next.boot = fbp_pkg::FBP_BOOT_USER;
      end else if (st_reg.sync_a[1] && !st_reg.sync_b[1]) begin
        st_next.boot = fbp_pkg::FBP_BOOT_ROM;
      end else begin
        st_next.boot = fbp_pkg::FBP_BOOT_OTHER;
      end
    end

    // Registered read data, prepared in the setup phase
    if (rd_setup) begin
      case (sel)
        fbp_pkg::FBP_SEL_CTRL: begin
          st_next.rdata = {28'h0000000, expand_eff, st_reg.block_a, st_reg.area_sel,
                           st_reg.rw_en};
        end
        fbp_pkg::FBP_SEL_STATUS: begin
          st_next.rdata = {24'h000000, st_reg.expand_wr, (st_reg.id_st == fbp_pkg::FBP_ID_DONE),
                           vec_erased, st_reg.id_ok, prot_on, expand_eff, st_reg.boot};
        end
        fbp_pkg::FBP_SEL_PROTECT: st_next.rdata = {24'h000000, st_reg.protect};
        fbp_pkg::FBP_SEL_VECTOR: st_next.rdata = st_reg.vector;
        fbp_pkg::FBP_SEL_LOCK: st_next.rdata = {24'h000000, st_reg.lock};
        default: st_next.rdata = 32'h00000000;
      endcase
    end

    // Register writes
    if (wr_access) begin
      case (sel)
        fbp_pkg::FBP_SEL_CTRL: begin
          st_next.rw_en = pwdata_i[`FBP_CTRL_RW_EN];
          st_next.area_sel = pwdata_i[`FBP_CTRL_AREA_SEL];
          st_next.block_a = pwdata_i[`FBP_CTRL_BLOCK_A];
          // Held value; the forced high level hides it while rewrite is on
          st_next.expand_wr = pwdata_i[`FBP_CTRL_EXPAND];
          if (pwdata_i[`FBP_CTRL_RW_EN] && !st_reg.rw_en) begin
            st_next.block_a = 1'b1;
          end
        end
        fbp_pkg::FBP_SEL_PROTECT: begin
          // Software owns all eight bits, level bits included; no forcing here
          st_next.protect = pwdata_i[7:0];
        end
        fbp_pkg::FBP_SEL_VECTOR: st_next.vector = pwdata_i;
        fbp_pkg::FBP_SEL_ERASE: begin
          if (pwdata_i[`FBP_ERASE_PROT]) begin
            st_next.protect = `FBP_BYTE_ERASED;
          end
        end
        fbp_pkg::FBP_SEL_LOCK: st_next.lock = pwdata_i[`FBP_NUM_BLOCKS-1:0];
        default: begin
        end
      endcase
    end

    // Identifier compare, one byte per fetch and ready pair
    case (st_reg.id_st)
      fbp_pkg::FBP_ID_FETCH: st_next.id_st = fbp_pkg::FBP_ID_READY;
      fbp_pkg::FBP_ID_READY: begin
        if (prog_id_valid_i) begin
          last_bad = (prog_id_byte_i != id_rd_data);
          st_next.id_miss = st_reg.id_miss || last_bad;
          if (st_reg.id_idx == `FBP_ID_LAST) begin
            st_next.id_st = fbp_pkg::FBP_ID_DONE;
            st_next.id_ok = !(st_reg.id_miss || last_bad);
          end else begin
            st_next.id_idx = st_reg.id_idx + 3'h1;
            st_next.id_st = fbp_pkg::FBP_ID_FETCH;
          end
        end
      end
      fbp_pkg::FBP_ID_DONE: st_next.id_st = fbp_pkg::FBP_ID_DONE;
      default: st_next.id_st = fbp_pkg::FBP_ID_FETCH;
    endcase
    // A new session drops any earlier match
    if (prog_id_start_i) begin
      st_next.id_st = fbp_pkg::FBP_ID_FETCH;
      st_next.id_idx = 3'h0;
      st_next.id_miss = 1'b0;
      st_next.id_ok = 1'b0;
    end

    // Command gate; answer is a one-cycle pulse the cycle after the request
    st_next.accept = 1'b0;
    st_next.reject = 1'b0;
    if (prog_cmd_valid_i) begin
      par = (prog_mode_i == fbp_pkg::FBP_PM_PARALLEL);
      ser_can = (prog_mode_i == fbp_pkg::FBP_PM_SERIAL) || (prog_mode_i == fbp_pkg::FBP_PM_CAN);
      cpu_src = (prog_mode_i == fbp_pkg::FBP_PM_NONE) && st_reg.rw_en;
      ok = par || ser_can || cpu_src;
      if (par && prot_on) begin
        ok = 1'b0;
      end
      if (ser_can && !(st_reg.id_ok || vec_erased)) begin
        ok = 1'b0;
      end
      if (prog_cmd_i.boot_area && (prog_cmd_i.kind != fbp_pkg::FBP_CMD_READ) && !par) begin
        ok = 1'b0;
      end
      if (prog_cmd_i.byte_unit && (prog_cmd_i.kind == fbp_pkg::FBP_CMD_PROGRAM) && !par) begin
        ok = 1'b0;
      end
      if ((prog_cmd_i.kind != fbp_pkg::FBP_CMD_READ) && !prog_cmd_i.boot_area &&
          st_reg.lock[prog_cmd_i.block]) begin
        ok = 1'b0;
      end
      st_next.accept = ok;
      st_next.reject = !ok;
      // Erase of the protect block leaves the byte erased, over any same-cycle write
      if (ok && (prog_cmd_i.kind == fbp_pkg::FBP_CMD_ERASE) && !prog_cmd_i.boot_area &&
          (prog_cmd_i.block == `FBP_PROT_BLOCK)) begin
        st_next.protect = `FBP_BYTE_ERASED;
      end
    end

    // Chip-select 2 span exists only while block A is mapped
    st_next.cs2_hit = st_reg.block_a && (cpu_addr_i >= `FBP_CS2_LO) &&
                      (cpu_addr_i <= `FBP_CS2_HI);
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------

  // Synchronisers keep running through reset so straps are settled at release
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg <= '{
        sync_mode: 2'b00,
        sync_a: 2'b00,
        sync_b: 2'b00,
        captured: 1'b0,
        boot: fbp_pkg::FBP_BOOT_USER,
        rw_en: 1'b0,
        area_sel: 1'b0,
        block_a: 1'b0,
        expand_wr: 1'b0,
        protect: `FBP_PROT_RST,
        vector: `FBP_VEC_RST,
        lock: `FBP_LOCK_RST,
        id_st: fbp_pkg::FBP_ID_FETCH,
        id_idx: 3'h0,
        id_miss: 1'b0,
        id_ok: 1'b0,
        rdata: 32'h00000000,
        accept: 1'b0,
        reject: 1'b0,
        cs2_hit: 1'b0
      };
      st_reg.sync_mode <= st_next.sync_mode;
      st_reg.sync_a <= st_next.sync_a;
      st_reg.sync_b <= st_next.sync_b;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------

  // Zero-wait slave; unmapped addresses and writes to status answer with an error
  assign prdata_o = st_reg.rdata;
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i &&
                     ((sel == fbp_pkg::FBP_SEL_NONE) ||
                      (pwrite_i && (sel == fbp_pkg::FBP_SEL_STATUS)));

  assign boot_sel_o = st_reg.boot;
  // Boot contents reachable only in boot mode and only when selected
  assign shared_to_boot_o = (st_reg.boot == fbp_pkg::FBP_BOOT_ROM) && st_reg.area_sel;
  assign block_a_en_o = st_reg.block_a;
  assign expand_eff_o = expand_eff;
  assign cs2_hit_o = st_reg.cs2_hit;
  assign par_access_ok_o = !prot_on;
  assign id_ok_o = st_reg.id_ok || vec_erased;
  assign prog_id_ready_o = (st_reg.id_st == fbp_pkg::FBP_ID_READY);
  assign prog_cmd_accept_o = st_reg.accept;
  assign prog_cmd_reject_o = st_reg.reject;

endmodule : fbp_top

// *** tb/fbp_prog_model.sv ***
// Serial or CAN programmer model: identifier over the byte handshake.
// Assumes the bench calls send_id.
`timescale 1ns/10ps

module fbp_prog_model (
  input wire logic mclk_i,
  input wire logic id_ready_i,
  output logic id_start_o = 1'b0,
  output logic id_valid_o = 1'b0,
  output logic [7:0] id_byte_o = 8'h00
);
  // Seven bytes, lowest first; gap of at least 1 keeps valid low between bytes
  task automatic send_id(input logic [55:0] id, input int gap);
    int k;
    int w;
    @(posedge mclk_i);
    id_start_o <= 1'b1;
    @(posedge mclk_i);
    id_start_o <= 1'b0;
    for (k = 0; k < 7; k++) begin
      repeat (gap) @(posedge mclk_i);
      id_valid_o <= 1'b1;
      id_byte_o <= id[8*k +: 8];
      w = 0;
      do begin
        @(posedge mclk_i);
        w++;
      end while (id_ready_i !== 1'b1 && w < 50);
      id_valid_o <= 1'b0;
      id_byte_o <= ~id[8*k +: 8]; // Released line must not look like a held byte
    end
    repeat (2) @(posedge mclk_i);
  endtask : send_id
endmodule : fbp_prog_model

// *** tb/fbp_top_props.sv ***
// Checker bound to the flash boot/protect top module.
// Assumes fbp_pkg is compiled beforehand.
`timescale 1ns/10ps
`include "fbp_defines.svh"

module fbp_top_props (
  input logic mclk_i,
  input logic rst_i,
  input logic [19:0] cpu_addr_i,
  input fbp_pkg::fbp_prog_mode_e prog_mode_i,
  input logic prog_cmd_valid_i,
  input fbp_pkg::fbp_cmd_s prog_cmd_i,
  input logic prog_cmd_accept_o,
  input logic prog_cmd_reject_o,
  input fbp_pkg::fbp_boot_e boot_sel_o,
  input logic shared_to_boot_o,
  input logic block_a_en_o,
  input logic cs2_hit_o,
  input logic par_access_ok_o,
  input logic id_ok_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // Saturating count since reset release; selection settles before 7
  logic [2:0] run_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h7) begin
      run_q <= run_q + 3'h1;
    end
  end

  a_boot_sel_held: assert property (run_q == 3'h7 |-> $stable(boot_sel_o))
    else $error("boot changed");
  a_user_hides_boot: assert property (boot_sel_o != fbp_pkg::FBP_BOOT_ROM |-> !shared_to_boot_o)
    else $error("boot visible");
  a_cmd_one_answer: assert property (prog_cmd_valid_i |=> prog_cmd_accept_o != prog_cmd_reject_o)
    else $error("bad answer");
  a_cmd_no_stray: assert property (!prog_cmd_valid_i |=> !(prog_cmd_accept_o || prog_cmd_reject_o))
    else $error("stray answer");
  a_boot_area_par: assert property (prog_cmd_valid_i && prog_cmd_i.boot_area
    && prog_cmd_i.kind != fbp_pkg::FBP_CMD_READ
    && prog_mode_i != fbp_pkg::FBP_PM_PARALLEL |=> prog_cmd_reject_o)
    else $error("boot rewrite");
  a_byte_unit_par: assert property (prog_cmd_valid_i && prog_cmd_i.byte_unit
    && prog_cmd_i.kind == fbp_pkg::FBP_CMD_PROGRAM
    && prog_mode_i != fbp_pkg::FBP_PM_PARALLEL |=> prog_cmd_reject_o)
    else $error("byte program");
  a_protect_blocks: assert property (prog_cmd_valid_i && !par_access_ok_o
    && prog_mode_i == fbp_pkg::FBP_PM_PARALLEL |=> prog_cmd_reject_o)
    else $error("protect leak");
  a_id_gate: assert property (prog_cmd_valid_i && !id_ok_o && (prog_mode_i == fbp_pkg::FBP_PM_SERIAL
    || prog_mode_i == fbp_pkg::FBP_PM_CAN) |=> prog_cmd_reject_o)
    else $error("id leak");
  a_cs2_in_span: assert property (block_a_en_o && cpu_addr_i >= `FBP_CS2_LO
    && cpu_addr_i <= `FBP_CS2_HI |=> cs2_hit_o)
    else $error("cs2 missed");
  a_cs2_off: assert property (!block_a_en_o |=> !cs2_hit_o)
    else $error("cs2 stray");
  c_accept: cover property (prog_cmd_accept_o);
endmodule : fbp_top_props

bind fbp_top fbp_top_props u_props (.*);

// *** tb/flash_boot_and_protect_test.sv ***
// Self-checking bench for fbp_top: APB, strap resets, programmer commands.
// Assumes package, defines and model compiled first.
`timescale 1ns/10ps
`include "fbp_defines.svh"

module flash_boot_and_protect_test;
  localparam fbp_pkg::fbp_prog_mode_e NON = fbp_pkg::FBP_PM_NONE;
  localparam fbp_pkg::fbp_prog_mode_e SER = fbp_pkg::FBP_PM_SERIAL;
  localparam fbp_pkg::fbp_prog_mode_e PAR = fbp_pkg::FBP_PM_PARALLEL;
  localparam fbp_pkg::fbp_prog_mode_e CAN = fbp_pkg::FBP_PM_CAN;
  localparam fbp_pkg::fbp_cmd_kind_e RD = fbp_pkg::FBP_CMD_READ;
  localparam fbp_pkg::fbp_cmd_kind_e PG = fbp_pkg::FBP_CMD_PROGRAM;
  localparam fbp_pkg::fbp_cmd_kind_e ER = fbp_pkg::FBP_CMD_ERASE;
  logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, prog_id_byte_i, lfsr_q = 8'h58;
  logic [31:0] pwdata_i = 32'h0, prdata_o;
  logic pready_o, pslverr_o, prog_id_start_i, prog_id_valid_i, prog_id_ready_o;
  logic mode_strap_pin_i = 1'b0, boot_strap_pin_a_i = 1'b0, boot_strap_pin_b_i = 1'b0;
  logic [19:0] cpu_addr_i = 20'h0;
  fbp_pkg::fbp_prog_mode_e prog_mode_i = fbp_pkg::FBP_PM_NONE;
  fbp_pkg::fbp_cmd_s prog_cmd_i = '0;
  fbp_pkg::fbp_boot_e boot_sel_o;
  logic prog_cmd_valid_i = 1'b0, prog_cmd_accept_o, prog_cmd_reject_o, shared_to_boot_o;
  logic block_a_en_o, expand_eff_o, cs2_hit_o, par_access_ok_o, id_ok_o;
  logic [64:0] rq[$];
  logic [1:0] cq[$];
  logic [64:0] e_q;
  int err_count = 0, n_compared = 0;

  fbp_top uut (.*);
  fbp_prog_model u_prog (.mclk_i, .id_ready_i(prog_id_ready_o), .id_start_o(prog_id_start_i),
    .id_valid_o(prog_id_valid_i), .id_byte_o(prog_id_byte_i));

  // ----------------------------------------
  // Clock, random source, shared tasks
  // ----------------------------------------
  always #12.5 mclk_i = ~mclk_i;

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // Random CPU addresses straddle both ends of the chip-select 2 span
  always @(posedge mclk_i) begin
    lfsr_q <= lfsr_next(lfsr_q);
    cpu_addr_i <= {2'b00, lfsr_q[1:0], lfsr_q, 8'h00};
  end

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // One APB transfer; mask 0 skips the data check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic err);
    int w;
    w = 0;
    rq.push_back({err, d, m});
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      w++;
    end while (pready_o !== 1'b1 && w < 20);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(negedge mclk_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic cmd(input fbp_pkg::fbp_prog_mode_e md, input fbp_pkg::fbp_cmd_kind_e k,
                     input logic ba, input logic bu, input logic [2:0] b, input logic acc);
    cq.push_back({acc, ~acc});
    @(posedge mclk_i);
    prog_mode_i <= md;
    prog_cmd_valid_i <= 1'b1;
    prog_cmd_i <= fbp_pkg::fbp_cmd_s'({k, ba, bu, b});
    @(posedge mclk_i);
    prog_cmd_valid_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask : cmd

  // Mode and B straps flip after release to show the selection is held
  task automatic do_reset(input logic m, input logic a, input logic b, input int n);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    mode_strap_pin_i <= m;
    boot_strap_pin_a_i <= a;
    boot_strap_pin_b_i <= b;
    repeat (n) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    mode_strap_pin_i <= ~m;
    boot_strap_pin_b_i <= ~b;
    repeat (3) @(posedge mclk_i);
  endtask : do_reset

  task automatic conclude();
    chk("pending answers", 32'h0, cq.size());
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Monitors: oldest note against each result
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && rq.size() > 0) begin
      e_q = rq.pop_front();
      chk("pslverr", e_q[64], pslverr_o);
      if (!pwrite_i) chk("prdata", e_q[63:32] & e_q[31:0], prdata_o & e_q[31:0]);
    end
  end

  always @(posedge mclk_i) begin
    if (prog_cmd_accept_o === 1'b1 || prog_cmd_reject_o === 1'b1) begin
      chk("answer", cq.size() > 0 ? cq.pop_front() : 2'bxx, {prog_cmd_accept_o, prog_cmd_reject_o});
    end
  end

  // Watchdog sized well above the full sequence
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    logic [55:0] id;
    do_reset(1'b1, 1'b1, 1'b0, 16);
    apb(1'b0, `FBP_OFS_STATUS, {30'h0, fbp_pkg::FBP_BOOT_ROM}, 32'h3, 1'b0);
    wr(`FBP_OFS_CTRL, 32'h2);
    chk("to boot", 1'b1, shared_to_boot_o);
    wr(`FBP_OFS_CTRL, 32'h0);
    chk("to user", 1'b0, shared_to_boot_o);
    do_reset(1'b0, 1'b1, 1'b0, 3);
    apb(1'b0, `FBP_OFS_STATUS, {30'h0, fbp_pkg::FBP_BOOT_USER}, 32'h3, 1'b0);
    wr(`FBP_OFS_CTRL, 32'h2);
    chk("user mode", 1'b0, shared_to_boot_o);
    cmd(NON, RD, 1'b0, 1'b0, 3'h1, 1'b0);
    wr(`FBP_OFS_CTRL, 32'h1);
    chk("expand on", 1'b1, expand_eff_o);
    chk("block A", 1'b1, block_a_en_o);
    wr(`FBP_OFS_CTRL, 32'h0);
    chk("expand off", 1'b0, expand_eff_o);
    wr(`FBP_OFS_CTRL, 32'h9);
    wr(`FBP_OFS_CTRL, 32'h1);
    chk("expand held", 1'b1, expand_eff_o);
    wr(`FBP_OFS_CTRL, 32'h0);
    chk("expand late", 1'b0, expand_eff_o);
    wr(`FBP_OFS_CTRL, 32'h4);
    wr(`FBP_OFS_PROTECT, 32'h3f);
    chk("prot 00", 1'b0, par_access_ok_o);
    cmd(PAR, RD, 1'b0, 1'b0, 3'h1, 1'b0);
    wr(`FBP_OFS_PROTECT, 32'h00);
    chk("prot 00h", 1'b1, par_access_ok_o);
    cmd(PAR, RD, 1'b0, 1'b0, 3'h1, 1'b1);
    wr(`FBP_OFS_PROTECT, 32'hbf);
    chk("prot 10", 1'b0, par_access_ok_o);
    wr(`FBP_OFS_ERASE, 32'h1);
    apb(1'b0, `FBP_OFS_PROTECT, 32'hff, 32'hff, 1'b0);
    chk("prot FFh", 1'b1, par_access_ok_o);
    wr(`FBP_OFS_PROTECT, 32'h7f);
    cmd(SER, ER, 1'b0, 1'b0, `FBP_PROT_BLOCK, 1'b1);
    apb(1'b0, `FBP_OFS_PROTECT, 32'hff, 32'hff, 1'b0);
    cmd(SER, PG, 1'b1, 1'b0, 3'h1, 1'b0);
    cmd(PAR, ER, 1'b1, 1'b0, 3'h1, 1'b1);
    cmd(CAN, PG, 1'b0, 1'b1, 3'h1, 1'b0);
    cmd(PAR, PG, 1'b0, 1'b1, 3'h1, 1'b1);
    wr(`FBP_OFS_LOCK, 32'h4);
    apb(1'b0, `FBP_OFS_LOCK, 32'h4, 32'hff, 1'b0);
    cmd(PAR, ER, 1'b0, 1'b0, 3'h2, 1'b0);
    cmd(PAR, PG, 1'b0, 1'b0, 3'h3, 1'b1);
    wr(`FBP_OFS_VECTOR, 32'h12345678);
    cmd(SER, PG, 1'b0, 1'b0, 3'h1, 1'b0);
    for (k = 0; k < 7; k++) begin
      id[8*k +: 8] = lfsr_q;
      wr(`FBP_OFS_ID, {21'h0, k[2:0], lfsr_q});
    end
    u_prog.send_id(id, 1);
    @(negedge mclk_i);
    chk("id match", 1'b1, id_ok_o);
    cmd(SER, PG, 1'b0, 1'b0, 3'h1, 1'b1);
    cmd(CAN, ER, 1'b0, 1'b0, 3'h1, 1'b1);
    u_prog.send_id(id ^ {8'h01, 48'h0}, 2);
    @(negedge mclk_i);
    chk("id last", 1'b0, id_ok_o);
    cmd(CAN, RD, 1'b0, 1'b0, 3'h1, 1'b0);
    wr(`FBP_OFS_VECTOR, 32'hffffffff);
    chk("id bypass", 1'b1, id_ok_o);
    cmd(SER, PG, 1'b0, 1'b0, 3'h1, 1'b1);
    apb(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `FBP_OFS_STATUS, 32'h0, 32'h0, 1'b1);
    conclude();
  end
endmodule : flash_boot_and_protect_test
